// ---- verilog/drive_fault_reaction_sequencer.sv ----
// Fault reaction sequencer for one servo axis with an APB register slave.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: Reaction A drops torque, brake, ready together.
// RL2: A: after brake delay and standstill, code 02.
// RL3: Leave code 02 only after acknowledge.
// RL4: Brake coast delays brake until standstill.
// RL5: Coast on disable or on B fault.
// RL6: B: max-current ramp, ready open, timer.
// RL7: B standstill: brake, then torque off later.
// RL8: Ramp timeout: brake relay open, diag 140.
// RL9: Timeout diagnostic leaves sequence unchanged.
// RL10: After timeout, torque off after brake delay.
// RL11: Faulted enable loss forces axis state 0.
// RL12: Ready and watchdog open on A, B, failure.
// RL13: C: controlled stop, hold, reject motion.
// RL14: Resume motion after cause gone and acknowledge.
// RL15: External wiring locks power stage on drop.
// RL16: Ring lamp off on good telegrams.
// RL17: Lamp brighter further from optimum light.
// RL18: Ring master sends telegrams after boot.
// RL19: Ring lamp undefined during boot.
// RL20: Fault lamp lit from boot start to done.
// RL21: B brake at nmin or stop limit first.
// RL22: Timers are down-counters, one-cycle expiry.
module drive_fault_reaction_sequencer #(
   parameter int STOP_CYC = fault_seq_pkg::STOP_LIMIT_CYC,
   parameter int BRAKE_CYC = fault_seq_pkg::BRAKE_DELAY_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault requests and sensing, synchronous to pclk.
   input wire logic fault_a,
   input wire logic fault_b,
   input wire logic fault_c,
   input wire logic component_fail,
   input wire logic [15:0] actual_speed,
   input wire logic motion_cmd,
   // Ring receiver status, asynchronous.
   input wire logic ring_telegram_ok,
   input wire logic [7:0] ring_light_level,
   // Drive outputs.
   output logic torque_enable,
   output logic max_current_ramp,
   output logic brake_release,
   output logic ready_contact_out,
   output logic watchdog_contact_out,
   output logic controlled_stop_request,
   output logic motion_accept,
   output logic [7:0] drive_state_code,
   output logic [2:0] axis_state_code,
   output logic [9:0] diag_code,
   output logic diag_pulse,
   // Lamps.
   output logic fault_lamp,
   output logic [7:0] ring_lamp_level
);
   // ****************************************************************
   // State record.
   // ****************************************************************
   typedef struct packed {
      fault_seq_pkg::seq_state_t st;
      logic [5:0] ctrl;        // Software control bits.
      logic [15:0] nmin;       // Standstill threshold.
      logic [31:0] ramp_load;  // Ramp-down limit in cycles.
      logic [31:0] brake_load; // Brake engage delay in cycles.
      logic [31:0] ramp_cnt;   // Ramp-down down-counter.
      logic [31:0] brake_cnt;  // Brake delay down-counter.
      logic ramp_run;
      logic brake_run;
      logic brake_started;     // Brake delay already launched.
      logic diag_pend;         // Diagnostic awaiting acknowledge.
      logic [9:0] diag;
      logic diag_p;
      logic [31:0] rdata;
      logic [2:0] ok_sync;     // Telegram-ok synchroniser.
      logic ok_q;
      logic [7:0] lamp;
   } state_t;

   state_t cur_ff;
   state_t nxt_ff;

   // Twice the distance of the light level from the optimum, saturating.
   function automatic logic [7:0] light_dist(input logic [7:0] lvl);
      logic [7:0] d;
      begin
         d = lvl[7] ? lvl - 8'h80 : 8'h80 - lvl;
         light_dist = d[7] ? 8'hFF : {d[6:0], 1'b0};
      end
   endfunction : light_dist

   // Down-counter step; expiry is flagged for exactly one cycle.
   function automatic logic [31:0] count_down(input logic [31:0] c);
      begin
         count_down = (c == 32'h0000_0000) ? c : c - 32'h0000_0001;
      end
   endfunction : count_down

   logic apb_wr;
   logic apb_rd;
   logic standstill;
   logic ramp_exp;
   logic brake_exp;
   logic enable;
   logic ack;
   logic severe;

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   assign standstill = actual_speed < cur_ff.nmin;
   // Expiry pulses come from the counters reaching one while running.
   assign ramp_exp = cur_ff.ramp_run && (cur_ff.ramp_cnt == 32'h0000_0001); // RL22
   assign brake_exp = cur_ff.brake_run && (cur_ff.brake_cnt == 32'h0000_0001); // RL22
   assign enable = cur_ff.ctrl[fault_seq_pkg::CTRL_ENABLE_BIT];
   assign ack = cur_ff.ctrl[fault_seq_pkg::CTRL_ACK_BIT];
   assign severe = fault_a || fault_b || component_fail;

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   // One process computes the whole next record.
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.diag_p = 1'b0;
      // Acknowledge is a self-clearing strobe bit.
      nxt_ff.ctrl[fault_seq_pkg::CTRL_ACK_BIT] = 1'b0;
      // Timers count down every cycle while armed.
      if (cur_ff.ramp_run) begin
         nxt_ff.ramp_cnt = count_down(cur_ff.ramp_cnt); // RL22
         nxt_ff.ramp_run = cur_ff.ramp_cnt > 32'h0000_0001;
      end
      if (cur_ff.brake_run) begin
         nxt_ff.brake_cnt = count_down(cur_ff.brake_cnt); // RL22
         nxt_ff.brake_run = cur_ff.brake_cnt > 32'h0000_0001;
      end
      unique case (cur_ff.st)
         fault_seq_pkg::ST_RUN: begin
            nxt_ff.brake_started = 1'b0;
            if (fault_a) begin
               // Outputs drop torque, brake and ready now.
               nxt_ff.st = fault_seq_pkg::ST_BRAKE; // RL1
               if (!cur_ff.ctrl[fault_seq_pkg::CTRL_BRAKE_COAST_BIT]) begin
                  nxt_ff.brake_cnt = cur_ff.brake_load;
                  nxt_ff.brake_run = 1'b1;
                  nxt_ff.brake_started = 1'b1;
               end
            end else if (fault_b && cur_ff.ctrl[fault_seq_pkg::CTRL_COAST_FLT_BIT]) begin
               nxt_ff.st = fault_seq_pkg::ST_BRAKE; // RL5
            end else if (fault_b) begin
               nxt_ff.st = fault_seq_pkg::ST_RAMP; // RL6
               nxt_ff.ramp_cnt = cur_ff.ramp_load;
               nxt_ff.ramp_run = 1'b1;
            end else if (!enable && cur_ff.ctrl[fault_seq_pkg::CTRL_COAST_DIS_BIT]) begin
               nxt_ff.st = fault_seq_pkg::ST_BRAKE; // RL5
            end else if (fault_c) begin
               nxt_ff.st = fault_seq_pkg::ST_STOP; // RL13
               nxt_ff.diag_pend = 1'b1;
            end
            if (severe) begin
               nxt_ff.diag_pend = 1'b1;
            end
         end
         fault_seq_pkg::ST_RAMP: begin
            // Brake at standstill or at the limit, whichever is first.
            if (standstill) begin
               nxt_ff.st = fault_seq_pkg::ST_COAST; // RL7
               nxt_ff.ramp_run = 1'b0;
               nxt_ff.brake_cnt = cur_ff.brake_load;
               nxt_ff.brake_run = 1'b1;
            end else if (ramp_exp) begin
               // Diagnostic only; the sequence carries on unchanged.
               nxt_ff.st = fault_seq_pkg::ST_COAST; // RL8 RL21
               nxt_ff.diag = fault_seq_pkg::DIAG_RAMP_EXCEEDED; // RL9
               nxt_ff.diag_p = 1'b1;
               nxt_ff.brake_cnt = cur_ff.brake_load;
               nxt_ff.brake_run = 1'b1;
            end
         end
         fault_seq_pkg::ST_COAST: begin
            // Torque is removed when the brake delay expires; coasting is silent.
            if (brake_exp) begin
               nxt_ff.st = fault_seq_pkg::ST_HALT; // RL7 RL10
            end
         end
         fault_seq_pkg::ST_BRAKE: begin
            // Coast options start the brake delay only at standstill.
            if (!cur_ff.brake_started && standstill) begin
               nxt_ff.brake_cnt = cur_ff.brake_load; // RL4
               nxt_ff.brake_run = 1'b1;
               nxt_ff.brake_started = 1'b1;
            end
            if (cur_ff.brake_started && !cur_ff.brake_run && standstill) begin
               nxt_ff.st = fault_seq_pkg::ST_HALT; // RL2 RL4
            end
         end
         fault_seq_pkg::ST_HALT: begin
            if (ack && !severe) begin
               nxt_ff.st = fault_seq_pkg::ST_RUN; // RL3
               nxt_ff.diag_pend = 1'b0;
            end
         end
         fault_seq_pkg::ST_STOP: begin
            if (fault_a || fault_b) begin
               nxt_ff.st = fault_seq_pkg::ST_BRAKE;
               nxt_ff.brake_cnt = cur_ff.brake_load;
               nxt_ff.brake_run = 1'b1;
               nxt_ff.brake_started = 1'b1;
            end else if (ack && !fault_c) begin
               nxt_ff.st = fault_seq_pkg::ST_RUN; // RL14
               nxt_ff.diag_pend = 1'b0;
            end
         end
         default: begin
            nxt_ff.st = fault_seq_pkg::ST_RUN;
         end
      endcase
      // Register writes take effect in the access phase.
      if (apb_wr) begin
         unique case (paddr)
            fault_seq_pkg::CTRL_OFS: nxt_ff.ctrl = pwdata[5:0];
            fault_seq_pkg::SPD_OFS: nxt_ff.nmin = pwdata[15:0];
            fault_seq_pkg::RAMP_OFS: nxt_ff.ramp_load = pwdata;
            fault_seq_pkg::BRAKE_OFS: nxt_ff.brake_load = pwdata;
            default: ;
         endcase
      end
      // Read data is captured in setup so the access phase needs no wait.
      if (apb_rd) begin
         unique case (paddr)
            fault_seq_pkg::CTRL_OFS: nxt_ff.rdata = {26'h0, cur_ff.ctrl};
            fault_seq_pkg::STAT_OFS: nxt_ff.rdata = {9'h0, cur_ff.diag_pend, cur_ff.diag,
               drive_state_code, 1'b0, axis_state_code};
            fault_seq_pkg::SPD_OFS: nxt_ff.rdata = {16'h0, cur_ff.nmin};
            fault_seq_pkg::RAMP_OFS: nxt_ff.rdata = cur_ff.ramp_load;
            fault_seq_pkg::BRAKE_OFS: nxt_ff.rdata = cur_ff.brake_load;
            fault_seq_pkg::LAMP_OFS: nxt_ff.rdata = {24'h0, cur_ff.lamp};
            default: nxt_ff.rdata = 32'h0000_0000;
         endcase
      end
      // Three-stage synchroniser; only the agreeing later stages are used.
      nxt_ff.ok_sync = {cur_ff.ok_sync[1:0], ring_telegram_ok};
      if (cur_ff.ok_sync[1] == cur_ff.ok_sync[2]) begin
         nxt_ff.ok_q = cur_ff.ok_sync[2];
      end
      // Lamp level is only meaningful once boot has finished.
      if (cur_ff.ok_q) begin
         nxt_ff.lamp = 8'h00; // RL16
      end else begin
         nxt_ff.lamp = light_dist(ring_light_level) | 8'h01; // RL17 RL19
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   // The whole record resets to constants only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= '0;
         cur_ff.nmin <= fault_seq_pkg::NMIN_RESET;
         cur_ff.ramp_load <= 32'(STOP_CYC);
         cur_ff.brake_load <= 32'(BRAKE_CYC);
         cur_ff.lamp <= 8'hFF;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   logic in_run;
   assign in_run = (cur_ff.st == fault_seq_pkg::ST_RUN) && !fault_a && !fault_b;
   assign torque_enable = (in_run && enable) || cur_ff.st == fault_seq_pkg::ST_RAMP ||
      cur_ff.st == fault_seq_pkg::ST_STOP || (cur_ff.st == fault_seq_pkg::ST_COAST); // RL1
   assign max_current_ramp = cur_ff.st == fault_seq_pkg::ST_RAMP; // RL6
   assign brake_release = (in_run && enable) || cur_ff.st == fault_seq_pkg::ST_RAMP ||
      cur_ff.st == fault_seq_pkg::ST_STOP ||
      (cur_ff.st == fault_seq_pkg::ST_BRAKE && !cur_ff.brake_started); // RL1 RL4 RL7
   assign ready_contact_out = !severe && (cur_ff.st == fault_seq_pkg::ST_RUN ||
      cur_ff.st == fault_seq_pkg::ST_STOP); // RL1 RL12
   assign watchdog_contact_out = !severe && (cur_ff.st == fault_seq_pkg::ST_RUN ||
      cur_ff.st == fault_seq_pkg::ST_STOP); // RL12 RL15
   assign controlled_stop_request = cur_ff.st == fault_seq_pkg::ST_STOP; // RL13
   assign motion_accept = in_run && enable && !fault_c && motion_cmd; // RL13 RL14
   assign drive_state_code = (cur_ff.st == fault_seq_pkg::ST_HALT) ?
      fault_seq_pkg::DRIVE_HALT : fault_seq_pkg::DRIVE_RUN; // RL2
   assign axis_state_code = !fault_a && !fault_b && ((in_run && enable) ||
      cur_ff.st == fault_seq_pkg::ST_STOP) ? fault_seq_pkg::AXIS_ON : fault_seq_pkg::AXIS_OFF; // RL11
   assign diag_code = cur_ff.diag;
   assign diag_pulse = cur_ff.diag_p;
   assign fault_lamp = !cur_ff.ctrl[fault_seq_pkg::CTRL_BOOT_DONE_BIT] || cur_ff.diag_pend; // RL20
   assign ring_lamp_level = cur_ff.lamp;
   assign prdata = cur_ff.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_fault_a_drop: assert property (fault_a |-> !torque_enable || cur_ff.st != fault_seq_pkg::ST_RUN)
      else $error("Torque not removed on reaction A."); // RL1
   a_ready_open: assert property (severe |-> !ready_contact_out && !watchdog_contact_out)
      else $error("Safety contacts closed during fault."); // RL12
   a_halt_code: assert property (cur_ff.st == fault_seq_pkg::ST_HALT |-> drive_state_code == 8'h02)
      else $error("Halt code wrong."); // RL2
   a_halt_ack: assert property ($past(cur_ff.st) == fault_seq_pkg::ST_HALT &&
      cur_ff.st == fault_seq_pkg::ST_RUN |-> $past(ack))
      else $error("Left halt without acknowledge."); // RL3
   a_ramp_diag: assert property (cur_ff.st == fault_seq_pkg::ST_RAMP && ramp_exp && !standstill
      |=> diag_pulse && diag_code == 10'h08C)
      else $error("Ramp timeout diagnostic missing."); // RL8
   a_axis_zero: assert property ((fault_a || fault_b) |-> axis_state_code == 3'h0)
      else $error("Axis state not zero under fault."); // RL11
   a_stop_hold: assert property (cur_ff.st == fault_seq_pkg::ST_STOP |-> !motion_accept &&
      controlled_stop_request)
      else $error("Motion accepted during stop."); // RL13
   a_ring_off: assert property (cur_ff.ok_q |=> ring_lamp_level == 8'h00)
      else $error("Ring lamp lit with good telegrams."); // RL16
   c_ramp: cover property (cur_ff.st == fault_seq_pkg::ST_RAMP ##1 cur_ff.st == fault_seq_pkg::ST_COAST);
   c_halt: cover property (cur_ff.st == fault_seq_pkg::ST_HALT);
   c_stop: cover property (cur_ff.st == fault_seq_pkg::ST_STOP);
endmodule : drive_fault_reaction_sequencer
`default_nettype wire

// ---- verilog/fault_seq_pkg.sv ----
// Package with the constants shared by the fault reaction sequencer.
package fault_seq_pkg;
   // ****************************************************************
   // Register map (APB byte addresses).
   // ****************************************************************
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] SPD_OFS = 12'h008;
   localparam logic [11:0] RAMP_OFS = 12'h00C;
   localparam logic [11:0] BRAKE_OFS = 12'h010;
   localparam logic [11:0] LAMP_OFS = 12'h014;
   // Control register field positions.
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_COAST_DIS_BIT = 1;
   localparam int CTRL_COAST_FLT_BIT = 2;
   localparam int CTRL_BRAKE_COAST_BIT = 3;
   localparam int CTRL_ACK_BIT = 4;
   localparam int CTRL_BOOT_DONE_BIT = 5;
   // ****************************************************************
   // Reset values and timing.
   // ****************************************************************
   localparam logic [15:0] NMIN_RESET = 16'h000A;
   localparam int CLK_MHZ = 100;
   localparam int STOP_LIMIT_MS = 400;
   localparam int BRAKE_DELAY_MS = 500;
   localparam int STOP_LIMIT_CYC = STOP_LIMIT_MS * 1000 * CLK_MHZ;
   localparam int BRAKE_DELAY_CYC = BRAKE_DELAY_MS * 1000 * CLK_MHZ;
   // Drive and axis state codes.
   localparam logic [7:0] DRIVE_RUN = 8'h04;
   localparam logic [7:0] DRIVE_HALT = 8'h02;
   localparam logic [2:0] AXIS_OFF = 3'h0;
   localparam logic [2:0] AXIS_ON = 3'h4;
   localparam logic [9:0] DIAG_RAMP_EXCEEDED = 10'h08C;
   // Sequencer states, Gray coded in declaration order.
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_RAMP = 3'h1,
      ST_BRAKE = 3'h3,
      ST_COAST = 3'h2,
      ST_HALT = 3'h6,
      ST_STOP = 3'h7
   } seq_state_t;
endpackage : fault_seq_pkg

// ---- testbench/axis_plant_model.sv ----
// Model of the power stage, holding brake and safety wiring.
`timescale 1ns/1ps
`default_nettype none
module axis_plant_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the sequencer.
   input wire logic torque_enable,
   input wire logic max_current_ramp,
   input wire logic brake_release,
   input wire logic ready_contact_out,
   // Speed set-up from the bench.
   input wire logic speed_load,
   input wire logic [15:0] speed_value,
   input wire logic [15:0] decel_step,
   // Plant state.
   output logic [15:0] actual_speed,
   output logic stage_locked,
   output logic mains_engaged
);
   // ****************************************************************
   // Safety wiring.
   // ****************************************************************
   // A dropped ready contact locks the stage; mains stay in.
   assign stage_locked = !ready_contact_out;
   assign mains_engaged = 1'b1;
   // ****************************************************************
   // Axis speed.
   // ****************************************************************
   // Slows only under brake or live ramp; a zero step never stops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         actual_speed <= 16'h0000;
      end else if (speed_load) begin
         actual_speed <= speed_value;
      end else if (!brake_release || (max_current_ramp && torque_enable)) begin
         actual_speed <= (actual_speed > decel_step) ? actual_speed - decel_step : 16'h0000;
      end
   end
endmodule : axis_plant_model
`default_nettype wire

// ---- testbench/drive_fault_reaction_sequencer_tb_top.sv ----
// Self-checking bench for the fault reaction sequencer.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_reaction_sequencer_tb_top;
   // Short timer values keep the run brief.
   localparam int STOP_N = 20;
   localparam int BRAKE_N = 10;
   localparam logic [31:0] BASE = 32'h00000021; // Enable and boot done.
   localparam logic [31:0] ACK = 32'h00000010;
   // Ring table, entry i at bit i (flags) or byte i (levels): telegram flag, light level, lamp.
   localparam logic [5:0] RING_OK = 6'h01;
   localparam logic [47:0] RING_LVL = 48'h0080A0709080;
   localparam logic [47:0] RING_EXP = 48'hFF0141212100;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic fault_a, fault_b, fault_c, component_fail, motion_cmd, ring_telegram_ok;
   logic [7:0] ring_light_level, drive_state_code, ring_lamp_level;
   logic [15:0] actual_speed, speed_value, decel_step;
   logic speed_load, torque_enable, max_current_ramp, brake_release, ready_contact_out;
   logic watchdog_contact_out, controlled_stop_request, motion_accept, diag_pulse, fault_lamp;
   logic [2:0] axis_state_code;
   logic [9:0] diag_code;
   logic stage_locked, mains_engaged;
   int failures, tests_run, n, i, pulses;
   // ****************************************************************
   // Design, far side and clock.
   // ****************************************************************
   drive_fault_reaction_sequencer #(.STOP_CYC(STOP_N), .BRAKE_CYC(BRAKE_N)) dut (.*);
   axis_plant_model plant (.*);
   // A free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Counts diagnostic pulses so a second one is seen.
   always @(posedge pclk) begin
      if (diag_pulse === 1'b1) begin
         pulses++;
      end
   end
   // ****************************************************************
   // Tasks.
   // ****************************************************************
   // Compares with case equality, so an unknown never matches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // Waits k edges and samples after the updates.
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask : cyc
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Loads speed and per-cycle deceleration into the plant.
   task automatic spin(input logic [15:0] v, input logic [15:0] s);
      @(posedge pclk);
      speed_load <= 1'b1;
      speed_value <= v;
      decel_step <= s;
      @(posedge pclk);
      speed_load <= 1'b0;
   endtask : spin
   // Clears all causes, acknowledges, expects the run code.
   task automatic recover(input string what);
      @(posedge pclk);
      fault_a <= 1'b0;
      fault_b <= 1'b0;
      fault_c <= 1'b0;
      component_fail <= 1'b0;
      spin(16'h0000, 16'h0000);
      apb(1'b1, fault_seq_pkg::CTRL_OFS, BASE | ACK);
      cyc(3);
      chk(32'(drive_state_code), 32'(fault_seq_pkg::DRIVE_RUN), "code after ack");
      $display("test %s done", what);
   endtask : recover
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   // Cuts a hang short long after the tests should have ended.
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      {presetn, psel, penable, pwrite, fault_a, fault_b, fault_c} = '0;
      {component_fail, motion_cmd, ring_telegram_ok, speed_load} = '0;
      {paddr, pwdata, speed_value, decel_step, pulses} = '0;
      ring_light_level = 8'h80;
      failures = 0;
      tests_run = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk(32'(fault_lamp), 32'h1, "fault lamp during boot");
      apb(1'b0, fault_seq_pkg::SPD_OFS, 32'h0);
      chk(rd, 32'(fault_seq_pkg::NMIN_RESET), "standstill threshold reset");
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      apb(1'b1, fault_seq_pkg::RAMP_OFS, STOP_N);
      apb(1'b1, fault_seq_pkg::BRAKE_OFS, BRAKE_N);
      apb(1'b1, fault_seq_pkg::CTRL_OFS, BASE);
      cyc(2);
      chk(32'(fault_lamp), 32'h0, "fault lamp after boot");
      apb(1'b0, fault_seq_pkg::STAT_OFS, 32'h0);
      chk(rd, 32'h00000044, "status when running");
      // Reaction A: all drop at once; halt needs standstill.
      spin(16'h0200, 16'h0020);
      @(posedge pclk);
      fault_a <= 1'b1;
      cyc(2);
      chk(32'(torque_enable), 32'h0, "A torque");
      chk(32'(brake_release), 32'h0, "A brake");
      chk(32'(ready_contact_out), 32'h0, "A ready");
      chk(32'(watchdog_contact_out), 32'h0, "A watchdog");
      chk(32'({stage_locked, mains_engaged}), 32'h3, "A stage lock");
      chk(32'(axis_state_code), 32'h0, "A axis state");
      cyc(BRAKE_N + 1);
      chk(32'(drive_state_code), 32'h04, "A code before standstill");
      for (n = 0; n < 40 && drive_state_code !== 8'h02; n++) cyc(1);
      chk(32'(actual_speed < 16'h000A), 32'h1, "A halt at standstill");
      chk(32'(drive_state_code), 32'h02, "A halt code");
      @(posedge pclk);
      fault_a <= 1'b0;
      cyc(5);
      chk(32'(drive_state_code), 32'h02, "halt held without ack");
      recover("reaction A");
      // Reaction B reaching standstill inside the limit.
      spin(16'h0100, 16'h0020);
      pulses = 0;
      @(posedge pclk);
      fault_b <= 1'b1;
      cyc(2);
      chk(32'(max_current_ramp), 32'h1, "B ramp");
      chk(32'(ready_contact_out), 32'h0, "B ready");
      chk(32'(torque_enable), 32'h1, "B torque while ramping");
      for (n = 0; n < 40 && brake_release !== 1'b0; n++) cyc(1);
      chk(32'(actual_speed < 16'h000A), 32'h1, "B brake at standstill");
      cyc(BRAKE_N - 3);
      chk(32'(torque_enable), 32'h1, "B torque in brake delay");
      cyc(6);
      chk(32'(torque_enable), 32'h0, "B torque after delay");
      chk(pulses, 32'h0, "no timeout diagnostic");
      recover("reaction B in time");
      // Reaction B whose ramp-down limit runs out.
      spin(16'h1000, 16'h0000);
      pulses = 0;
      @(posedge pclk);
      fault_b <= 1'b1;
      cyc(STOP_N - 3);
      chk(32'(brake_release), 32'h1, "B brake before limit");
      cyc(6);
      chk(32'(brake_release), 32'h0, "B brake at limit");
      chk(32'(diag_code), 32'(fault_seq_pkg::DIAG_RAMP_EXCEEDED), "timeout code");
      chk(pulses, 32'h1, "timeout pulse");
      chk(32'(torque_enable), 32'h1, "torque kept after timeout");
      chk(32'(axis_state_code), 32'h0, "axis kept off");
      cyc(BRAKE_N + 3);
      chk(32'(torque_enable), 32'h0, "torque off after delay");
      chk(pulses, 32'h1, "coasting raises nothing");
      recover("reaction B timeout");
      // Coasting: brake coast with A, coast on B fault, coast on disable.
      for (i = 0; i < 3; i++) begin
         spin(16'h0400, 16'h0020);
         apb(1'b1, fault_seq_pkg::CTRL_OFS, (i == 0) ? 32'h29 : (i == 1) ? 32'h25 : 32'h22);
         @(posedge pclk);
         fault_a <= (i == 0);
         fault_b <= (i == 1);
         cyc(8);
         chk(32'(torque_enable), 32'h0, "coast torque");
         chk(32'(brake_release), 32'h1, "coast brake held open");
         spin(16'h0000, 16'h0000);
         cyc(3);
         chk(32'(brake_release), 32'h0, "coast brake at standstill");
         cyc(BRAKE_N + 3);
         chk(32'(drive_state_code), 32'h02, "coast halt code");
         recover("coasting");
      end
      // Reaction C: stop, motion refused until cause gone and acked.
      @(posedge pclk);
      fault_c <= 1'b1;
      motion_cmd <= 1'b1;
      cyc(2);
      chk(32'(controlled_stop_request), 32'h1, "C stop request");
      chk(32'(motion_accept), 32'h0, "C motion refused");
      chk(32'(torque_enable), 32'h1, "C holds position");
      apb(1'b1, fault_seq_pkg::CTRL_OFS, BASE | ACK);
      cyc(2);
      chk(32'(motion_accept), 32'h0, "ack with cause present");
      @(posedge pclk);
      fault_c <= 1'b0;
      cyc(3);
      chk(32'(motion_accept), 32'h0, "cause gone without ack");
      apb(1'b1, fault_seq_pkg::CTRL_OFS, BASE | ACK);
      cyc(2);
      chk(32'(motion_accept), 32'h1, "motion resumed");
      chk(32'(controlled_stop_request), 32'h0, "stop withdrawn");
      // A failed component opens both contacts.
      @(posedge pclk);
      component_fail <= 1'b1;
      cyc(2);
      chk(32'(ready_contact_out), 32'h0, "fail ready");
      chk(32'(watchdog_contact_out), 32'h0, "fail watchdog");
      recover("reaction C and failure");
      // Ring lamp over the table; telegrams run once boot is over.
      for (i = 0; i < 6; i++) begin
         @(posedge pclk);
         ring_telegram_ok <= RING_OK[i];
         ring_light_level <= RING_LVL[8 * i +: 8];
         cyc(6);
         chk(32'(ring_lamp_level), 32'(RING_EXP[8 * i +: 8]), "ring lamp");
         apb(1'b0, fault_seq_pkg::LAMP_OFS, 32'h0);
         chk(rd, 32'(RING_EXP[8 * i +: 8]), "ring lamp register");
      end
      $display("test ring lamp done");
      tally_and_finish();
   end
endmodule : drive_fault_reaction_sequencer_tb_top
`default_nettype wire
